// File: pkg/psm_pkg.sv
package psm_pkg;
    // ==========================================================
    // register offsets (byte addresses)
    // ==========================================================
    localparam logic [3:0] SERIAL_CONTROL_OFS  = 4'h0;
    localparam logic [3:0] SERIAL_STATUS_OFS   = 4'h4;
    localparam logic [3:0] TRANSFER_DATA_OFS   = 4'h8;
    localparam logic [3:0] CLOCK_DIVIDER_OFS   = 4'hc;
    // ==========================================================
    // control register fields
    // ==========================================================
    localparam int CTL_SOFT_RESET_BIT = 15;
    localparam int CTL_CHIP_SEL_BIT   = 14;
    localparam int CTL_COUNT_HI       = 8;
    localparam int CTL_COUNT_LO       = 4;
    localparam int CTL_ORDER_BIT      = 3;
    localparam int CTL_CPHA_BIT       = 2;
    localparam int CTL_CPOL_BIT       = 1;
    localparam int CTL_AUTO_BIT       = 0;
    // control resets with chip select high (deselected)
    localparam logic [15:0] CTL_RESET = 16'h4000;
    // ==========================================================
    // status and divider fields
    // ==========================================================
    localparam int STS_WIDTH_HI    = 7;
    localparam int STS_WIDTH_LO    = 6;
    localparam int STS_ACTIVE_BIT  = 0;
    localparam int DIV_BYPASS_BIT  = 15;
    localparam int DIV_VALUE_HI    = 7;
    localparam logic [15:0] DIV_RESET = 16'h0000;
    // serial clock is system clock divided by this base figure times (divider-1), or by it alone if bypassed or divider is below two
    localparam int BASE_DIVIDE     = 4;
    // ==========================================================
    // width exponents
    // ==========================================================
    localparam int WIDTH_EXP_MIN   = 3;
    localparam int WIDTH_EXP_DEF   = 5;
endpackage : psm_pkg

// File: core/psm_shift_reg.sv
`timescale 1ns/10ps
// ==========================================================
// shift register holding transmit and receive bits
// ==========================================================
module psm_shift_reg #(
    parameter int WIDTH = 32
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             load_i,     // load transmit word
    input  wire logic [WIDTH-1:0] load_data_i,
    input  wire logic             shift_i,    // one bit step
    input  wire logic             lsb_first_i,
    input  wire logic             rx_bit_i,
    output logic      [WIDTH-1:0] data_o,     // registered contents
    output logic                  tx_bit_o    // bit now on the line
);
    // load wins over shift; received bit enters from the far end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            data_o <= '0;
        end else if (load_i) begin
            data_o <= load_data_i;
        end else if (shift_i) begin
            if (lsb_first_i) begin
                data_o <= {rx_bit_i, data_o[WIDTH-1:1]};
            end else begin
                data_o <= {data_o[WIDTH-2:0], rx_bit_i};
            end
        end
    end

    // outgoing bit comes from the end being shifted out
    always_comb begin
        tx_bit_o = lsb_first_i ? data_o[0] : data_o[WIDTH-1];
    end
endmodule : psm_shift_reg

// File: core/psm_top.sv
`timescale 1ns/10ps
module psm_top #(
    parameter int WIDTH_EXP = psm_pkg::WIDTH_EXP_DEF  // 3, 4 or 5
) (
    input  wire logic        CORE_CLK_I,
    input  wire logic        RESET_N_I,
    input  wire logic [3:0]  ADDR_I,
    input  wire logic [31:0] WDATA_I,
    input  wire logic        WR_I,
    input  wire logic        RD_I,
    output logic      [31:0] RDATA_O,
    output logic             SCLK_O,
    output logic             MOSI_O,
    input  wire logic        MISO_I,
    output logic             CHIP_SELECT_N_O
);
    localparam int WIDTH = 1 << WIDTH_EXP;
    localparam logic [1:0] WIDTH_CODE = 2'(WIDTH_EXP - psm_pkg::WIDTH_EXP_MIN);

    // ==========================================================
    // reset release
    // ==========================================================
    // reset asserts at once but lets go only on a clock edge,
    // so no flop leaves reset part way through a cycle
    logic rst_meta_r;  // first stage, read only by second
    logic rst_n;       // released reset for the block
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            rst_meta_r <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n      <= rst_meta_r;
        end
    end

    // ==========================================================
    // registers
    // ==========================================================
    logic [15:0] control_r;   // serial_control
    logic [15:0] divider_r;   // serial_clock_divider
    logic        tx_wr;       // transmit data write
    logic        rx_rd;       // receive data read
    // field views of the control word, named for what they select, plus the active flag and shift register outputs
    logic        controller_soft_reset;
    logic        transfer_active_flag;
    logic        bit_order_select;
    logic        cpha;
    logic        cpol;
    logic [4:0]  bit_count_minus_one;
    logic [WIDTH-1:0] shift_data;
    logic        tx_bit;

    // ==========================================================
    // shared decode
    // ==========================================================
    // transmit and receive words share one offset, so both the
    // write path and the read path ask the same question
    function automatic logic is_data_addr(input logic [3:0] addr);
        return addr == psm_pkg::TRANSFER_DATA_OFS;
    endfunction : is_data_addr

    // data word strobes, one per direction
    assign tx_wr = WR_I && is_data_addr(ADDR_I);
    assign rx_rd = RD_I && is_data_addr(ADDR_I);
    assign controller_soft_reset = control_r[psm_pkg::CTL_SOFT_RESET_BIT];
    assign bit_order_select      = control_r[psm_pkg::CTL_ORDER_BIT];
    assign cpha                  = control_r[psm_pkg::CTL_CPHA_BIT];
    assign cpol                  = control_r[psm_pkg::CTL_CPOL_BIT];
    assign bit_count_minus_one   = control_r[psm_pkg::CTL_COUNT_HI:psm_pkg::CTL_COUNT_LO];

    // software writes to control and divider
    // control keeps every bit as written; the spare ones read back
    // so that software sees what it stored
    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            control_r <= psm_pkg::CTL_RESET;
            divider_r <= psm_pkg::DIV_RESET;
        end else if (WR_I) begin
            if (ADDR_I == psm_pkg::SERIAL_CONTROL_OFS) begin
                control_r <= WDATA_I[15:0];
            end
            if (ADDR_I == psm_pkg::CLOCK_DIVIDER_OFS) begin
                divider_r <= WDATA_I[15:0] & 16'h80ff;
            end
        end
    end

    // chip select pin follows its control bit
    // the pin lags its bit by one cycle; software sets the select
    // before the trigger access, so the lag never shortens setup
    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            CHIP_SELECT_N_O <= 1'b1;
        end else begin
            CHIP_SELECT_N_O <= control_r[psm_pkg::CTL_CHIP_SEL_BIT];
        end
    end

    // read data in the cycle after the strobe; unmapped reads zero
    // zero outside the answer cycle lets read data of several
    // blocks be combined with a plain or on the system side
    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            RDATA_O <= '0;
        end else if (RD_I) begin
            case (ADDR_I)
                psm_pkg::SERIAL_CONTROL_OFS: RDATA_O <= {16'h0000, control_r};
                psm_pkg::SERIAL_STATUS_OFS:  RDATA_O <= {24'h000000, WIDTH_CODE, 5'h00,
                                                         transfer_active_flag};
                psm_pkg::TRANSFER_DATA_OFS:  RDATA_O <= 32'(shift_data);
                psm_pkg::CLOCK_DIVIDER_OFS:  RDATA_O <= {16'h0000, divider_r};
                default:                     RDATA_O <= '0;
            endcase
        end else begin
            RDATA_O <= '0;
        end
    end

    // ==========================================================
    // half-bit enable divider
    // ==========================================================
    // a full serial period is four base ticks times (divider-1);
    // we toggle every half period, i.e. two ticks times (divider-1)
    // ten bits hold the longest half period, 2 * 254 cycles
    logic [9:0] tick_cnt_r;   // counts system cycles per half period
    logic [9:0] half_len;     // cycles per half period
    logic       half_tick;    // one-cycle enable at each half period
    logic       busy;

    // divider values below two would leave no period at all, so
    // they fall back to the undivided base rate, like the bypass
    // divide by four times divider minus one
    always_comb begin
        if (divider_r[psm_pkg::DIV_BYPASS_BIT] || divider_r[7:0] < 8'h02) begin
            half_len = 10'(psm_pkg::BASE_DIVIDE / 2);
        end else begin
            half_len = 10'(psm_pkg::BASE_DIVIDE / 2) * {2'b00, 8'(divider_r[7:0] - 8'h01)};
        end
    end

    // divider only runs during a transfer so each bit starts aligned
    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_r <= '0;
        end else if (!busy || half_tick) begin
            tick_cnt_r <= '0;
        end else begin
            tick_cnt_r <= tick_cnt_r + 10'h001;
        end
    end
    assign half_tick = busy && (tick_cnt_r == half_len - 10'h001);

    // ==========================================================
    // transfer state machine
    // ==========================================================
    // one-hot codes keep each state a single flop to decode
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,   // waiting for a trigger
        ST_LEAD  = 3'b010,   // first half of a bit
        ST_TRAIL = 3'b100    // second half of a bit
    } psm_state_t;

    psm_state_t  state_r;
    logic [5:0]  bits_left_r;  // bits still to finish
    logic        start;
    logic        shift_en;
    logic        sample_r;     // captured input bit

    // a trigger is refused while busy or in soft reset, so a word
    // in flight is never cut short by a second access
    // auto trigger on data access
    assign start = control_r[psm_pkg::CTL_AUTO_BIT] && (tx_wr || rx_rd)
                   && state_r == ST_IDLE && !controller_soft_reset;
    assign busy  = state_r != ST_IDLE;

    // soft reset wins over every other event in the same cycle
    // soft reset holds the controller idle
    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            state_r     <= ST_IDLE;
            bits_left_r <= '0;
        end else if (controller_soft_reset) begin
            state_r     <= ST_IDLE;
            bits_left_r <= '0;
        end else begin
            case (state_r)
                // wait for an accepted trigger
                ST_IDLE: begin
                    if (start) begin
                        state_r     <= ST_LEAD;
                        // counts above the register width are a software error:
                        // the extra bits sent are those just received
                        // count field plus one bits
                        bits_left_r <= {1'b0, bit_count_minus_one} + 6'h01;
                    end
                end
                // first half: the far side samples at its end
                ST_LEAD: begin
                    if (half_tick) begin
                        state_r <= ST_TRAIL;
                    end
                end
                // second half: the bit is shifted at its end
                ST_TRAIL: begin
                    if (half_tick) begin
                        if (bits_left_r == 6'h01) begin
                            state_r <= ST_IDLE;
                        end else begin
                            state_r <= ST_LEAD;
                        end
                        bits_left_r <= bits_left_r - 6'h01;
                    end
                end
                // an illegal code falls back to idle
                default: state_r <= ST_IDLE;
            endcase
        end
    end
    assign transfer_active_flag = busy;

    // capture input in mid bit, shift at bit end
    // mid-bit capture leaves the far side half a bit period to
    // settle after its own launch edge
    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            sample_r <= 1'b0;
        end else if (state_r == ST_LEAD && half_tick) begin
            sample_r <= MISO_I;
        end
    end
    assign shift_en = state_r == ST_TRAIL && half_tick && !controller_soft_reset;

    // a load is taken only while idle: a write during a transfer
    // is dropped rather than corrupt the word on the line
    // bit order and capture
    psm_shift_reg #(
        .WIDTH (WIDTH)
    ) u_shift (
        .clk_i       (CORE_CLK_I),
        .rst_n_i     (rst_n),
        .load_i      (tx_wr && !busy),
        .load_data_i (WDATA_I[WIDTH-1:0]),
        .shift_i     (shift_en),
        .lsb_first_i (bit_order_select),
        .rx_bit_i    (sample_r),
        .data_o      (shift_data),
        .tx_bit_o    (tx_bit)
    );

    // ==========================================================
    // serial pins
    // ==========================================================
    // clock level for one half of a bit; with phase clear the lead
    // half sits at the idle level, so the first edge is mid bit
    function automatic logic half_level(input logic pol, input logic pha, input logic lead);
        return lead ? (pol ^ pha) : (pol ^ ~pha);
    endfunction : half_level

    // phase picks which edge leads the bit
    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            SCLK_O <= 1'b0;
        end else if (state_r == ST_LEAD) begin
            SCLK_O <= half_level(cpol, cpha, 1'b1);
        end else if (state_r == ST_TRAIL) begin
            SCLK_O <= half_level(cpol, cpha, 1'b0);
        end else begin
            SCLK_O <= cpol;
        end
    end

    // data line presents the current outgoing bit
    // registered so it moves on the same cycle as the clock pin,
    // which is also one cycle behind the state
    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            MOSI_O <= 1'b0;
        end else begin
            MOSI_O <= tx_bit;
        end
    end
endmodule : psm_top

// File: tb/psm_properties.sv
`timescale 1ns/10ps
// ====================================
// port checks of the serial master
module psm_properties #(
    parameter int WIDTH_EXP = 5
) (
    input wire logic        CORE_CLK_I,
    input wire logic        RESET_N_I,
    input wire logic [3:0]  ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic        WR_I,
    input wire logic        RD_I,
    input wire logic [31:0] RDATA_O,
    input wire logic        SCLK_O,
    input wire logic        MOSI_O,
    input wire logic        MISO_I,
    input wire logic        CHIP_SELECT_N_O
);
    localparam logic [1:0] WCODE = 2'(WIDTH_EXP - 3);
    logic [15:0] ctl_r; // shadow of control, defined bits
    logic [15:0] div_r; // shadow of divider, defined bits
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!RESET_N_I);
    // shadows follow bus writes only
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            ctl_r <= psm_pkg::CTL_RESET;
            div_r <= psm_pkg::DIV_RESET;
        end else if (WR_I && ADDR_I == 4'h0) begin
            ctl_r <= WDATA_I[15:0] & 16'hc1ff;
        end else if (WR_I && ADDR_I == 4'hc) begin
            div_r <= WDATA_I[15:0] & 16'h80ff;
        end
    end
    sequence s_trig;
        (WR_I || RD_I) && ADDR_I == 4'h8 && ctl_r[0] && !ctl_r[15];
    endsequence
    sequence s_stat;
        RD_I && ADDR_I == 4'h4;
    endsequence
    property p_rdata_zero;
        !RD_I |=> RDATA_O == 32'h0;
    endproperty
    a_rdata_zero: assert property (p_rdata_zero) else $error("read data not idle");
    property p_unmapped;
        RD_I && ADDR_I[1:0] != 2'h0 |=> RDATA_O == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_width;
        s_stat |=> RDATA_O[7:6] == WCODE;
    endproperty
    a_width: assert property (p_width) else $error("width code wrong");
    property p_ctl;
        RD_I && ADDR_I == 4'h0 |=> (RDATA_O[15:0] & 16'hc1ff) == ctl_r;
    endproperty
    a_ctl: assert property (p_ctl) else $error("control readback wrong");
    property p_div;
        RD_I && ADDR_I == 4'hc |=> (RDATA_O[15:0] & 16'h80ff) == div_r;
    endproperty
    a_div: assert property (p_div) else $error("divider readback wrong");
    property p_cs;
        $changed(ctl_r[14]) |=> CHIP_SELECT_N_O == ctl_r[14];
    endproperty
    a_cs: assert property (p_cs) else $error("select does not follow control");
    // a trigger must show as active on a status poll one or two cycles later
    property p_busy;
        s_trig ##[1:2] s_stat |=> RDATA_O[0];
    endproperty
    a_busy: assert property (p_busy) else $error("active flag missing");
    property p_soft;
        WR_I && ADDR_I == 4'h0 && WDATA_I[15] |-> ##4 SCLK_O == $past(WDATA_I[1], 4);
    endproperty
    a_soft: assert property (p_soft) else $error("clock not idle in soft reset");
endmodule : psm_properties
bind psm_top psm_properties #(.WIDTH_EXP(WIDTH_EXP)) u_props (
    .CORE_CLK_I(CORE_CLK_I), .RESET_N_I(RESET_N_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
    .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .SCLK_O(SCLK_O), .MOSI_O(MOSI_O),
    .MISO_I(MISO_I), .CHIP_SELECT_N_O(CHIP_SELECT_N_O));

// File: tb/psm_spi_slave.sv
`timescale 1ns/10ps
// ====================================
// far-side serial slave stand-in
module psm_spi_slave (
    input  wire logic        sclk_i,
    input  wire logic        mosi_i,
    input  wire logic        cs_n_i,
    input  wire logic        cpol_i,
    input  wire logic        cpha_i,
    input  wire logic        load_i,  // reload reply, clear log
    input  wire logic [31:0] word_i,
    output logic             miso_o,
    output logic [31:0]      rx_o,    // bits seen, latest at bit 0
    output logic [7:0]       count_o, // sample edges seen
    output logic [31:0]      period_o // ns between last samples
);
    logic [31:0] tx_q;
    logic        armed;
    time         t_last;
    initial tx_q = 32'h0;
    always @(posedge load_i) begin
        tx_q = word_i;
        rx_o = 32'h0;
        count_o = 8'h0;
        armed = 1'b0;
    end
    // sample mid-bit, step only on the boundary after a sample
    always @(sclk_i) begin
        if (sclk_i !== (cpol_i ^ cpha_i)) begin
            rx_o = {rx_o[30:0], mosi_i};
            count_o++;
            period_o = 32'($time - t_last);
            t_last = $time;
            armed = 1'b1;
        end else if (armed) begin
            tx_q = {tx_q[30:0], 1'b0};
            armed = 1'b0;
        end
    end
    // deselected line shows the inverse, never a stale bit
    assign miso_o = cs_n_i ? ~tx_q[31] : tx_q[31];
endmodule : psm_spi_slave

// File: tb/polled_spi_master_bench.sv
`timescale 1ns/10ps
// ====================================
// bench of the polled serial master
module polled_spi_master_bench;
    logic        clk, rst_n, wr, rd, miso, sclk, mosi, cs_n, s_ld;
    logic [3:0]  addr;
    logic [15:0] ctl_v;
    logic [31:0] wdata, rdata, v, s_word, s_rx, s_per;
    logic [7:0]  s_cnt;
    int          num_errors = 0, n_checks = 0, cyc = 0;
    psm_top u_dut (.CORE_CLK_I(clk), .RESET_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
        .RD_I(rd), .RDATA_O(rdata), .SCLK_O(sclk), .MOSI_O(mosi), .MISO_I(miso), .CHIP_SELECT_N_O(cs_n));
    psm_spi_slave u_slv (.sclk_i(sclk), .mosi_i(mosi), .cs_n_i(cs_n), .cpol_i(ctl_v[1]), .cpha_i(ctl_v[2]),
        .load_i(s_ld), .word_i(s_word), .miso_o(miso), .rx_o(s_rx), .count_o(s_cnt), .period_o(s_per));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // hang guard, far above the expected run
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            final_report();
        end
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    // data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask : rd_reg
    // configure, rearm the slave, trigger, then poll until idle
    task automatic xfer(input logic [15:0] c, input logic [31:0] tx, input logic by_rd);
        int n;
        wr_reg(4'h0, {16'h0, c});
        ctl_v <= c;
        repeat (4) @(posedge clk);
        s_ld <= 1'b1;
        @(posedge clk);
        s_ld <= 1'b0;
        if (by_rd) rd_reg(4'h8, v);
        else wr_reg(4'h8, tx);
        rd_reg(4'h4, v);
        chk("busy", v & 32'h1, 32'h1);
        n = 0;
        while (v[0] !== 1'b0 && n < 4000) begin
            rd_reg(4'h4, v);
            n++;
        end
        chk("done", v & 32'h1, 32'h0);
    endtask : xfer
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report
    initial begin
        rst_n = 1'b0;
        addr = 4'h0;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        s_ld = 1'b0;
        ctl_v = 16'h4000;
        s_word = 32'h0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd_reg(4'h0, v);
        chk("control", v, 32'h4000);
        rd_reg(4'h4, v);
        chk("status", v & 32'hc1, 32'h80);
        rd_reg(4'h1, v);
        chk("unmapped", v, 32'h0);
        wr_reg(4'h4, 32'hff);
        rd_reg(4'h4, v);
        chk("status ro", v & 32'hc1, 32'h80);
        wr_reg(4'hc, 32'h8012);
        rd_reg(4'hc, v);
        chk("divider", v & 32'h80ff, 32'h8012);
        wr_reg(4'hc, 32'h3);
        $display("registers done");
        // all four clock modes, full width, bit time 4*(3-1) cycles
        for (int m = 0; m < 4; m++) begin
            s_word <= 32'h5a3c96e1 + m;
            xfer({7'h0, 5'd31, 1'b0, m[0], m[1], 1'b1}, 32'hc3a50f69 - m, 1'b0);
            chk("tx stream", s_rx, 32'hc3a50f69 - m);
            chk("bit count", {24'h0, s_cnt}, 32'd32);
            chk("bit time", s_per, 32'd400);
            chk("idle clock", {31'h0, sclk}, {31'h0, m[1]});
            chk("select", {31'h0, cs_n}, 32'h0);
            wr_reg(4'h0, {16'h0, ctl_v & 16'hfffe});
            rd_reg(4'h8, v);
            chk("rx word", v, s_word);
        end
        $display("clock modes done");
        // first byte lowest, each byte bit-reversed on the line
        xfer(16'h0179, 32'h00ccbbaa, 1'b0);
        chk("lsb stream", s_rx, 32'h0055dd33);
        chk("lsb count", {24'h0, s_cnt}, 32'd24);
        wr_reg(4'h0, 32'h0070);
        wr_reg(4'h8, 32'haa000000);
        rd_reg(4'h4, v);
        chk("no trigger", v & 32'h1, 32'h0);
        xfer(16'h0071, 32'h0, 1'b1);
        chk("read trigger", s_rx, 32'haa);
        chk("short count", {24'h0, s_cnt}, 32'd8);
        $display("order and width done");
        // abort mid-word, then resume with the divider bypassed
        wr_reg(4'hc, 32'h8000);
        wr_reg(4'h0, 32'h01f1);
        wr_reg(4'h8, 32'hffffffff);
        repeat (20) @(posedge clk);
        wr_reg(4'h0, 32'h81f1);
        repeat (4) @(posedge clk);
        rd_reg(4'h4, v);
        chk("abort", v & 32'h1, 32'h0);
        xfer(16'h01f1, 32'h13572468, 1'b0);
        chk("resume", s_rx, 32'h13572468);
        chk("bypass time", s_per, 32'd200);
        $display("soft reset done");
        final_report();
    end
endmodule : polled_spi_master_bench
